// ===== common/qtu_pkg.sv
// Package for the quad timer unit: register map, field layout and state carriers
//
// Function
// - Four subsystems, prescaler, counter, compares, two pins
// - Dual 8-bit mode splits counter into two
// - Own run bit; prescaler runs if either runs
// - Increment when prescaler count equals limit field
// - Counter clears after reaching period value
// - Pin starts default, flips at 00h to 01h
// - Pin returns default after duty match increment
// - Duty above period gives full duty
// - Duty 00h keeps pin at default
// - Period/duty writes buffered until period match/stop
// - Reads return most recently written period/duty
// - Counter writable only while both runs clear
// - Preset counts on; pin waits for 00h-01h
// - Preset above period rolls over FFh to 00h
// - Run clear: pin default, counter holds, updates complete
// - Prescaler stops and clears when both runs clear
// - Sixteen sources, four per subsystem request line
// - Flags: low duty, low period, high duty, high period
// - Op select 00 low power, 01 dual PWM
// - Run bit one running, zero stopped
`default_nettype none

package qtu_pkg;

  localparam int NSUB = 4;
  localparam int NCH  = 2;
  localparam int DW   = 16;
  localparam int AW   = 5;
  // Address split: group from this bit up, index below it
  localparam int GRP_LSB = 2;

  // Address = {group, index}
  localparam logic [2:0] GRP_CTRL   = 3'h0;
  localparam logic [2:0] GRP_PRESC  = 3'h1;
  localparam logic [2:0] GRP_COUNT  = 3'h2;
  localparam logic [2:0] GRP_PERIOD = 3'h3;
  localparam logic [2:0] GRP_DUTY   = 3'h4;
  localparam logic [1:0] IDX_MODE   = 2'h0;
  localparam logic [1:0] IDX_PINCTL = 2'h1;
  localparam logic [1:0] IDX_INTEN  = 2'h2;
  localparam logic [1:0] IDX_INTPND = 2'h3;

  // Mode register: one nibble per subsystem
  localparam int MODE_STRIDE = 4;
  localparam int RUN_LSB     = 0;
  localparam int OP_LSB      = 2;
  localparam int OP_W        = 2;
  localparam logic [1:0] OP_LOWPWR = 2'h0;
  localparam logic [1:0] OP_DUAL8  = 2'h1;

  // Pending flags per subsystem
  localparam int FLG_PER_SUB = 4;
  localparam int FLG_LODUTY  = 0;
  localparam int FLG_LOPER   = 1;
  localparam int FLG_HIDUTY  = 2;
  localparam int FLG_HIPER   = 3;

  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          we;
    logic          re;
  } qtu_bus_s;

  typedef struct packed {
    logic [15:0]                  mode;
    logic [7:0]                   pinDflt;
    logic [15:0]                  intEn;
    logic [15:0]                  intPnd;
    logic [NSUB-1:0][7:0]         presc;
    logic [NSUB-1:0][7:0]         pscCnt;
    logic [NSUB-1:0][NCH-1:0][7:0] cnt;
    logic [NSUB-1:0][NCH-1:0][7:0] perW;
    logic [NSUB-1:0][NCH-1:0][7:0] dtyW;
    logic [NSUB-1:0][NCH-1:0][7:0] perA;
    logic [NSUB-1:0][NCH-1:0][7:0] dtyA;
    logic [7:0]                   act;
    logic [7:0]                   pin;
    logic [7:0]                   pinOe;
    logic [NSUB-1:0]              irq;
    logic [DW-1:0]                rdata;
  } qtu_state_s;

endpackage

`default_nettype wire

// ===== rtl/qtu_quad_timer.sv
// Quad timer unit: four subsystems of dual 8-bit PWM channels with register port
`timescale 1ns/100ps
`default_nettype none

module qtu_quad_timer
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire qtu_pkg::qtu_bus_s bus,
  output logic [qtu_pkg::DW-1:0] rdata,
  // PWM pins, two per subsystem
  output logic [7:0]             pwmOut,
  output logic [7:0]             pwmOe,
  // One request per subsystem
  output logic [3:0]             irq
);

  qtu_pkg::qtu_state_s st_r;
  qtu_pkg::qtu_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [2:0]  grp;
    logic [1:0]  idx;
    logic [15:0] pndSet;
    logic [15:0] pndClr;
    logic        opDual;
    logic        anyRun;
    logic        tick;
    logic [1:0]  run;
    logic [7:0]  nextCnt;
    logic        perHit;
    logic        dtyHit;
    int          ch;
    grp    = bus.addr[qtu_pkg::AW-1:qtu_pkg::GRP_LSB];
    idx    = bus.addr[qtu_pkg::GRP_LSB-1:0];
    pndSet = '0;
    pndClr = '0;
    opDual = 1'b0;
    anyRun = 1'b0;
    tick   = 1'b0;
    run    = '0;
    nextCnt = '0;
    perHit = 1'b0;
    dtyHit = 1'b0;
    ch     = 0;
    st_nxt = st_r;
    st_nxt.rdata = '0;

    // Control register writes
    if (bus.we && grp == qtu_pkg::GRP_CTRL)
    begin
      unique case (idx)
        qtu_pkg::IDX_MODE:   st_nxt.mode    = bus.wdata;
        qtu_pkg::IDX_PINCTL: st_nxt.pinDflt = bus.wdata[7:0];
        qtu_pkg::IDX_INTEN:  st_nxt.intEn   = bus.wdata;
        qtu_pkg::IDX_INTPND: pndClr         = bus.wdata;
      endcase
    end

    for (int s = 0; s < qtu_pkg::NSUB; s++)
    begin
      opDual = st_nxt.mode[s*qtu_pkg::MODE_STRIDE+qtu_pkg::OP_LSB +: qtu_pkg::OP_W] == qtu_pkg::OP_DUAL8;
      for (int c = 0; c < qtu_pkg::NCH; c++)
        run[c] = st_r.mode[s*qtu_pkg::MODE_STRIDE+qtu_pkg::RUN_LSB+c] && opDual;
      anyRun = |run;
      tick   = anyRun && st_r.pscCnt[s] == st_r.presc[s];

      // Low power freezes everything and blocks writes and flag clears
      if (!opDual)
      begin
        for (int f = 0; f < qtu_pkg::FLG_PER_SUB; f++)
          pndClr[s*qtu_pkg::FLG_PER_SUB+f] = 1'b0;
      end
      else
      begin
        if (bus.we && grp == qtu_pkg::GRP_PRESC && idx == 2'(s))
          st_nxt.presc[s] = bus.wdata[7:0];
        if (bus.we && grp == qtu_pkg::GRP_COUNT && idx == 2'(s) && !anyRun)
          st_nxt.cnt[s] = bus.wdata;
        if (bus.we && grp == qtu_pkg::GRP_PERIOD && idx == 2'(s))
          st_nxt.perW[s] = bus.wdata;
        if (bus.we && grp == qtu_pkg::GRP_DUTY && idx == 2'(s))
          st_nxt.dtyW[s] = bus.wdata;

        // Shared prescaler
        if (!anyRun)
          st_nxt.pscCnt[s] = qtu_pkg::BYTE_ZERO;
        else if (tick)
          st_nxt.pscCnt[s] = qtu_pkg::BYTE_ZERO;
        else
          st_nxt.pscCnt[s] = st_r.pscCnt[s] + qtu_pkg::BYTE_ONE;

        for (int c = 0; c < qtu_pkg::NCH; c++)
        begin
          ch      = s * qtu_pkg::NCH + c;
          perHit  = st_r.cnt[s][c] == st_r.perA[s][c];
          dtyHit  = st_r.cnt[s][c] == st_r.dtyA[s][c];
          nextCnt = perHit ? qtu_pkg::BYTE_ZERO : st_r.cnt[s][c] + qtu_pkg::BYTE_ONE;

          if (run[c] && tick)
          begin
            st_nxt.cnt[s][c] = nextCnt;
            // Flag events share the increment that acts on the match
            if (dtyHit)
              pndSet[s*qtu_pkg::FLG_PER_SUB + (c == 0 ? qtu_pkg::FLG_LODUTY : qtu_pkg::FLG_HIDUTY)] = 1'b1;
            if (perHit)
              pndSet[s*qtu_pkg::FLG_PER_SUB + (c == 0 ? qtu_pkg::FLG_LOPER : qtu_pkg::FLG_HIPER)] = 1'b1;

            // Duty match return wins only when duty fits in the period
            if (nextCnt == qtu_pkg::BYTE_ONE && st_r.dtyA[s][c] != qtu_pkg::BYTE_ZERO)
              st_nxt.act[ch] = 1'b1;
            else if (dtyHit && st_r.dtyA[s][c] <= st_r.perA[s][c])
              st_nxt.act[ch] = 1'b0;
            if (st_r.dtyA[s][c] == qtu_pkg::BYTE_ZERO)
              st_nxt.act[ch] = 1'b0;
          end
          else if (!run[c])
            st_nxt.act[ch] = 1'b0;

          // New compares take hold at period match or while stopped
          if (!run[c] || (tick && perHit))
          begin
            st_nxt.perA[s][c] = st_nxt.perW[s][c];
            st_nxt.dtyA[s][c] = st_nxt.dtyW[s][c];
          end
        end
      end

      for (int c = 0; c < qtu_pkg::NCH; c++)
      begin
        ch = s * qtu_pkg::NCH + c;
        // Low power holds the pin where it stood, even across level writes
        if (opDual)
          st_nxt.pin[ch] = st_nxt.pinDflt[ch] ^ st_nxt.act[ch];
        st_nxt.pinOe[ch] = opDual;
      end
    end

    // Set wins over a clear in the same cycle
    st_nxt.intPnd = (st_r.intPnd & ~pndClr) | pndSet;
    for (int s = 0; s < qtu_pkg::NSUB; s++)
      st_nxt.irq[s] = |(st_nxt.intPnd[s*qtu_pkg::FLG_PER_SUB +: qtu_pkg::FLG_PER_SUB]
                       & st_nxt.intEn[s*qtu_pkg::FLG_PER_SUB +: qtu_pkg::FLG_PER_SUB]);

    // Read data for the following cycle
    if (bus.re)
    begin
      unique case (grp)
        qtu_pkg::GRP_CTRL:
        begin
          unique case (idx)
            qtu_pkg::IDX_MODE:   st_nxt.rdata = st_r.mode;
            qtu_pkg::IDX_PINCTL: st_nxt.rdata = {qtu_pkg::BYTE_ZERO, st_r.pinDflt};
            qtu_pkg::IDX_INTEN:  st_nxt.rdata = st_r.intEn;
            qtu_pkg::IDX_INTPND: st_nxt.rdata = st_r.intPnd;
          endcase
        end
        qtu_pkg::GRP_PRESC:  st_nxt.rdata = {qtu_pkg::BYTE_ZERO, st_r.presc[idx]};
        qtu_pkg::GRP_COUNT:  st_nxt.rdata = st_r.cnt[idx];
        qtu_pkg::GRP_PERIOD: st_nxt.rdata = st_r.perW[idx];
        qtu_pkg::GRP_DUTY:   st_nxt.rdata = st_r.dtyW[idx];
        default:             st_nxt.rdata = qtu_pkg::WORD_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      // Period resets to full scale so a started channel has a real cycle
      for (int s = 0; s < qtu_pkg::NSUB; s++)
      begin
        st_r.perW[s] <= '1;
        st_r.perA[s] <= '1;
      end
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata  = st_r.rdata;
  assign pwmOut = st_r.pin;
  assign pwmOe  = st_r.pinOe;
  assign irq    = st_r.irq;

endmodule

`default_nettype wire

// ===== verif/qtu_props.sv
// Checker for the quad timer unit ports
`timescale 1ns/100ps
`default_nettype none

module qtu_props
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Watched ports
  input wire qtu_pkg::qtu_bus_s bus,
  input wire logic [15:0]       rdata,
  input wire logic [7:0]        pwmOut,
  input wire logic [7:0]        pwmOe,
  input wire logic [3:0]        irq
);
  logic [15:0] mode_r;
  logic [15:0] en_r;
  logic [15:0] per_r;
  logic [15:0] dty_r;
  logic        dflt_r;

  // Shadows of software writes; compares refused outside dual PWM
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_r <= 16'h0000;
      en_r   <= 16'h0000;
      per_r  <= 16'hFFFF;
      dty_r  <= 16'h0000;
      dflt_r <= 1'b0;
    end
    else if (bus.we)
    begin
      if (bus.addr == 5'h00) mode_r <= bus.wdata;
      if (bus.addr == 5'h01) dflt_r <= bus.wdata[0];
      if (bus.addr == 5'h02) en_r <= bus.wdata;
      if (bus.addr == 5'h0C && mode_r[3:2] == 2'h1) per_r <= bus.wdata;
      if (bus.addr == 5'h10 && mode_r[3:2] == 2'h1) dty_r <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rdIdle; !$past(bus.re) |-> rdata == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  property p_rdPer; $past(bus.re && bus.addr == 5'h0C) |-> rdata == $past(per_r); endproperty
  a_rdPer: assert property (p_rdPer) else $error("period readback wrong");
  property p_rdDty; $past(bus.re && bus.addr == 5'h10) |-> rdata == $past(dty_r); endproperty
  a_rdDty: assert property (p_rdDty) else $error("duty readback wrong");
  property p_grp; $past(bus.re && bus.addr[4:2] > 3'h4) |-> rdata == 16'h0000; endproperty
  a_grp: assert property (p_grp) else $error("empty group read not zero");
  property p_oeMode; $stable(mode_r[3:2]) |-> pwmOe[1:0] == {2{mode_r[3:2] == 2'h1}}; endproperty
  a_oeMode: assert property (p_oeMode) else $error("pin enable disagrees with op select");
  property p_lpFrozen; (mode_r[3:2] != 2'h1 && $stable(mode_r[3:2])) |-> $stable(pwmOut[1:0]); endproperty
  a_lpFrozen: assert property (p_lpFrozen) else $error("pin moved in low power");
  property p_irqGate; (en_r[3:0] == 4'h0 && $past(en_r[3:0]) == 4'h0) |-> !irq[0]; endproperty
  a_irqGate: assert property (p_irqGate) else $error("request without enable");
  property p_runIdle; (mode_r[3:2] == 2'h1 && !mode_r[0] && $stable(dflt_r))[*3] |-> pwmOut[0] == dflt_r; endproperty
  a_runIdle: assert property (p_runIdle) else $error("stopped pin not at default");

  c_active: cover property (mode_r[0] && pwmOut[0] != dflt_r);
  c_irq: cover property (irq[0]);
  c_rdPer: cover property ($past(bus.re && bus.addr == 5'h0C));
endmodule

bind qtu_quad_timer qtu_props i_props (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pwmOut(pwmOut),
  .pwmOe(pwmOe), .irq(irq));

`default_nettype wire

// ===== verif/qtu_loads.sv
// External loads on the PWM pins
`timescale 1ns/100ps
`default_nettype none

module qtu_loads
(
  // Clock and measurement control
  input wire logic        clk,
  input wire logic        clr,
  // Pins
  input wire logic [7:0]  pwmOut,
  input wire logic [7:0]  pwmOe,
  output logic     [7:0]  pinLevel,
  output logic     [15:0] highCount
);
  // Loads pull undriven pins low
  assign pinLevel = pwmOut & pwmOe;

  always_ff @(posedge clk)
    highCount <= clr ? 16'h0000 : highCount + 16'(pinLevel[0]);
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
// Testbench for the quad timer unit
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              clr = 1'b1;
  qtu_pkg::qtu_bus_s bus = '0;
  logic [15:0]       rdata;
  logic [15:0]       cnt;
  logic [7:0]        pwmOut;
  logic [7:0]        pwmOe;
  logic [7:0]        lvl;
  logic [3:0]        irq;
  int                fail_count = 0;
  int                comparisons = 0;

  qtu_quad_timer i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pwmOut(pwmOut), .pwmOe(pwmOe), .irq(irq));
  qtu_loads i_load (.clk(clk), .clr(clr), .pwmOut(pwmOut), .pwmOe(pwmOe), .pinLevel(lvl), .highCount(cnt));

  initial
  begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle after each access keeps one assignment per time step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input string what, input logic [4:0] a, input logic [15:0] exp);
    bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus <= '0;
    #10;
    chk(what, exp, rdata);
    @(posedge clk);
  endtask

  // Whole periods only, so the start phase does not matter
  task automatic meas(input int n, input logic [15:0] exp);
    repeat (32) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #10;
    chk("high time", exp, cnt);
    @(posedge clk);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("period reset", 5'h0C, 16'hFFFF);
    rd("empty group", 5'h1C, 16'h0000);
    chk("oe reset", 16'h0000, {8'h00, pwmOe});
    wr(5'h00, 16'h0004);
    wr(5'h0C, 16'h0003);
    wr(5'h10, 16'h0002);
    wr(5'h00, 16'h0005);
    chk("oe dual", 16'h0003, {8'h00, pwmOe});
    meas(40, 16'h0014);
    wr(5'h04, 16'h0001);
    meas(80, 16'h0028);
    wr(5'h10, 16'h0004);
    rd("duty", 5'h10, 16'h0004);
    meas(80, 16'h0050);
    wr(5'h10, 16'h0000);
    meas(80, 16'h0000);
    wr(5'h0C, 16'h0007);
    rd("period", 5'h0C, 16'h0007);
    wr(5'h10, 16'h0004);
    meas(160, 16'h0050);
    wr(5'h02, 16'h0002);
    repeat (20) @(posedge clk);
    chk("irq", 16'h0001, {12'h000, irq});
    wr(5'h00, 16'h0004);
    #10;
    chk("pin stop", 16'h0000, {15'h0000, pwmOut[0]});
    @(posedge clk);
    wr(5'h03, 16'hFFFF);
    chk("irq clear", 16'h0000, {12'h000, irq});
    wr(5'h08, 16'h0006);
    rd("preset", 5'h08, 16'h0006);
    wr(5'h00, 16'h0006);
    wr(5'h08, 16'h0506);
    rd("count locked", 5'h08, 16'h0006);
    rd("pending high", 5'h03, 16'h000C);
    wr(5'h00, 16'h0004);
    wr(5'h01, 16'h0001);
    chk("pin default", 16'h0001, {15'h0000, pwmOut[0]});
    wr(5'h00, 16'h0000);
    chk("oe low power", 16'h0000, {8'h00, pwmOe});
    chk("load level", 16'h0000, {8'h00, lvl});
    end_sim();
  end

  initial
  begin
    #1000000;
    fail_count++;
    end_sim();
  end
endmodule

`default_nettype wire
